/* File: logic/repeater_port_status_and_event_regs.sv */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module repeater_port_status_and_event_regs (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Port state from the repeater core.
  input wire logic [12:0] link_bad,
  input wire logic [12:0] collision_active,
  input wire logic [12:0] rx_active,
  input wire logic [12:0] isolated,
  input wire logic [12:0][1:0] isolation_cause,
  input wire logic ext_xcvr_sel,
  // Port controls to the repeater core.
  output logic [12:0] port_kill,
  output logic [12:0] squelch_reduced,
  output logic [12:0] reconnect,
  // Mode load capture.
  input wire logic mode_load,
  input wire logic [7:0] option_pins,
  // Live interrupt events.
  input wire logic packet_start,
  input wire logic rx_source_event,
  input wire logic [3:0] rx_source_port,
  input wire logic first_col_event,
  input wire logic [3:0] first_col_port,
  input wire logic [12:0] isolation_change,
  // Counter and flag array summary.
  input wire logic [12:0][15:0] counter_value,
  input wire logic flag_found,
  // Counter controls.
  output logic [7:0] count_enable,
  output logic clear_on_read,
  output logic freeze_full,
  output logic tx_collision_count_en,
  output logic rx_collision_count_en,
  output logic late_collision_count_en,
  output logic [2:0] page_sel
);

  // Round-robin pick of the first pending port at or after start.
  function automatic logic [3:0] pick_port(input logic [12:0] pend, input logic [3:0] start);
    logic [3:0] found;
    logic hit;
    int idx;
    found = start;
    hit = 1'b0;
    for (int k = 0; k < repeater_regs_pkg::PORTS; k++) begin
      idx = int'(start) + k;
      if (idx >= repeater_regs_pkg::PORTS) begin
        idx = idx - repeater_regs_pkg::PORTS;
      end
      if (!hit && pend[idx]) begin
        hit = 1'b1;
        found = 4'(idx);
      end
    end
    return found;
  endfunction

  // Next port after p, wrapping at the last port.
  function automatic logic [3:0] next_port(input logic [3:0] p);
    return (p == 4'(repeater_regs_pkg::PORTS - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  logic acc_wait;
  logic acc_write;
  logic [7:0] acc_idx;
  logic [7:0] lower_mask;
  logic [7:0] upper_mask;
  logic [7:0] options;
  logic rx_pend;
  logic [3:0] rx_port;
  logic col_pend;
  logic [3:0] col_port;
  logic [12:0] part_pend;
  logic [3:0] poll_ptr;
  logic [12:0] rx_source_flag;
  logic [12:0] col_seen;
  logic [12:0] squelch_low_sel;
  logic [12:0][7:0] port_rd;
  logic [12:0] low_hit;
  logic [12:0] high_hit;
  logic [12:0] full_hit;

  // Bus decode. A transfer is taken in its address phase and served one cycle
  // later with one wait state, so read data always comes from a flip-flop and
  // a read that follows a write sees the written value.
  wire take = hsel & htrans[1] & hready;
  wire fire = acc_wait;
  wire wr_fire = fire & acc_write;
  wire rd_fire = fire & ~acc_write;
  wire [7:0] wdata = hwdata[7:0];
  wire page0 = page_sel == repeater_regs_pkg::PAGE_ZERO;
  wire hit_live = acc_idx == repeater_regs_pkg::IDX_LIVE_IRQ;
  wire hit_page = acc_idx == repeater_regs_pkg::IDX_PAGE;
  wire hit_lower = page0 & (acc_idx == repeater_regs_pkg::IDX_LOWER_MASK); // [R12]
  wire hit_upper = page0 & (acc_idx == repeater_regs_pkg::IDX_UPPER_MASK); // [R12]
  wire hit_opt = acc_idx == repeater_regs_pkg::IDX_OPTIONS;
  wire [7:0] port_off = acc_idx - repeater_regs_pkg::IDX_PORT_BASE;
  wire hit_port = (acc_idx >= repeater_regs_pkg::IDX_PORT_BASE) &&
                  (port_off < 8'(repeater_regs_pkg::PORTS));

  // Bus handshake; every response is OKAY.
  assign hreadyout = ~acc_wait;
  assign hresp = 1'b0;

  // Address phase capture.
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_wait <= 1'b0;
      acc_write <= 1'b0;
      acc_idx <= 8'h00;
    end else if (take) begin
      acc_wait <= 1'b1;
      acc_write <= hwrite;
      acc_idx <= haddr[9:2];
    end else begin
      acc_wait <= 1'b0;
    end
  end

  // Counter summary bits, one compare set per port.
  for (genvar p = 0; p < repeater_regs_pkg::PORTS; p++) begin : g_count
    assign low_hit[p] = counter_value[p] < repeater_regs_pkg::COUNT_LOW; // [R14]
    assign high_hit[p] = counter_value[p] > repeater_regs_pkg::COUNT_HIGH; // [R15]
    assign full_hit[p] = counter_value[p] == repeater_regs_pkg::COUNT_FULL; // [R16]
  end

  wire [7:0] page_rd = {|full_hit, |high_hit, |low_hit, flag_found, 1'b0, page_sel}; // [R13]

  // Live interrupt selection in fixed priority order.
  wire [3:0] part_pick = pick_port(part_pend, poll_ptr); // [R7]
  wire [3:0] part_addr = part_pick + 4'h1;
  wire part_any = |part_pend;
  wire sel_rx = rx_pend;
  wire sel_col = ~rx_pend & col_pend;
  wire sel_part = ~rx_pend & ~col_pend & part_any;
  wire [7:0] live_rd = sel_rx ? {rx_port, repeater_regs_pkg::CAUSE_RX} : // [R6] [R9] [R10]
                       sel_col ? {col_port, repeater_regs_pkg::CAUSE_FIRST_COL} : // [R25]
                       sel_part ? {part_addr, repeater_regs_pkg::CAUSE_PART} : // [R10]
                       repeater_regs_pkg::NO_IRQ; // [R11]
  wire live_read = rd_fire & hit_live;

  // Read data mux; unmapped words read as zero.
  wire [7:0] rd_mux = hit_live ? live_rd :
                      hit_page ? page_rd :
                      hit_lower ? lower_mask :
                      hit_upper ? upper_mask :
                      hit_opt ? options :
                      hit_port ? port_rd[port_off[3:0]] : 8'h00;

  // Read data register, loaded only on a read.
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_fire) begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // Receive and first-collision pending bits. A new event in the same cycle
  // as its clear wins, so nothing that arrives during the read is lost.
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_pend <= 1'b0;
      rx_port <= 4'h0;
      col_pend <= 1'b0;
      col_port <= 4'h0;
    end else begin
      if (rx_source_event) begin
        rx_pend <= 1'b1;
        rx_port <= rx_source_port;
      end else if (packet_start || (live_read && sel_rx)) begin
        rx_pend <= 1'b0; // [R5] [R8]
      end
      if (first_col_event) begin
        col_pend <= 1'b1;
        col_port <= first_col_port;
      end else if (packet_start || (live_read && sel_col)) begin
        col_pend <= 1'b0; // [R5] [R8]
      end
    end
  end

  // Partition and reconnection pending bits with the polling pointer.
  wire [12:0] part_clr = (live_read && sel_part) ? (13'h0001 << part_pick) : 13'h0000;
  wire [12:0] next_part = packet_start ? isolation_change : // [R5]
                          (part_pend & ~part_clr) | isolation_change; // [R8]

  always_ff @(posedge clock) begin
    if (rst) begin
      part_pend <= 13'h0000;
      poll_ptr <= 4'h0;
    end else begin
      part_pend <= next_part;
      if (live_read && sel_part) begin
        poll_ptr <= next_port(part_pick); // [R7]
      end
    end
  end

  // Lower, upper and page registers. Software is expected to set both
  // collision enables for all collisions, and only the late-collision enable
  // for late ones; the hardware does not police those combinations.
  always_ff @(posedge clock) begin
    if (rst) begin
      lower_mask <= repeater_regs_pkg::LOWER_MASK_RESET;
      upper_mask <= repeater_regs_pkg::UPPER_MASK_RESET;
      page_sel <= repeater_regs_pkg::PAGE_RESET;
    end else if (wr_fire) begin
      if (hit_lower) begin
        lower_mask <= wdata; // [R17]
      end
      if (hit_upper) begin
        upper_mask <= wdata & repeater_regs_pkg::UPPER_WMASK; // [R20]
      end
      if (hit_page) begin
        page_sel <= wdata[2:0]; // [R12]
      end
    end
  end

  // Counter controls handed to the event counters.
  assign count_enable = lower_mask; // [R17]
  assign clear_on_read = upper_mask[repeater_regs_pkg::UM_CLEAR_ON_READ]; // [R18]
  assign freeze_full = upper_mask[repeater_regs_pkg::UM_FREEZE_FULL]; // [R19]
  assign tx_collision_count_en = upper_mask[repeater_regs_pkg::UM_TX_COL]; // [R20]
  assign rx_collision_count_en = upper_mask[repeater_regs_pkg::UM_RX_COL]; // [R20]
  assign late_collision_count_en = upper_mask[repeater_regs_pkg::UM_LATE_COL]; // [R20]

  // Options are loaded only while mode load runs; bus writes never touch them.
  always_ff @(posedge clock) begin
    if (rst) begin
      options <= repeater_regs_pkg::OPTIONS_RESET;
    end else if (mode_load) begin
      options <= option_pins | repeater_regs_pkg::OPTIONS_RESET; // [R4]
    end
  end

  // Per-port status registers, one word each.
  for (genvar p = 0; p < repeater_regs_pkg::PORTS; p++) begin : g_port
    wire port_wr = wr_fire & hit_port & (port_off[3:0] == 4'(p));

    // Stored controls and the one-cycle reconnect strobe.
    always_ff @(posedge clock) begin
      if (rst) begin
        port_kill[p] <= 1'b0;
        squelch_low_sel[p] <= 1'b0;
        reconnect[p] <= 1'b0;
      end else begin
        reconnect[p] <= port_wr & wdata[repeater_regs_pkg::PP_PART]; // [R23]
        if (port_wr) begin
          port_kill[p] <= wdata[repeater_regs_pkg::PP_KILL]; // [R3]
          squelch_low_sel[p] <= wdata[repeater_regs_pkg::PP_SQUELCH];
        end
      end
    end

    // Sticky per-packet activity; restarts with each packet.
    always_ff @(posedge clock) begin
      if (rst) begin
        rx_source_flag[p] <= 1'b0;
        col_seen[p] <= 1'b0;
      end else if (packet_start) begin
        rx_source_flag[p] <= rx_active[p];
        col_seen[p] <= collision_active[p];
      end else begin
        rx_source_flag[p] <= rx_source_flag[p] | rx_active[p]; // [R24]
        col_seen[p] <= col_seen[p] | collision_active[p];
      end
    end

    // The reduced squelch only applies to the internal transceivers.
    assign squelch_reduced[p] = squelch_low_sel[p] & ~ext_xcvr_sel; // [R1]

    assign port_rd[p] = {port_kill[p], squelch_low_sel[p],
                         isolation_cause[p], // [R2]
                         ~isolated[p], ~rx_source_flag[p], // [R24]
                         ~col_seen[p], link_bad[p]};
  end

endmodule
`default_nettype wire

/* File: logic/repeater_regs_pkg.sv */
// Function
// R1: Squelch select 1 picks the reduced threshold; ignored with external transceivers.
// R2: Partition cause reads 00 collisions, 01 long collision, 10 loopback, 11 forced.
// R3: Port disable 1 blocks all port activity; 0 restores normal repeating.
// R4: Configuration register is read-only, holding options captured during mode load.
// R5: Unserviced live interrupts are discarded when the next packet starts.
// R6: Live interrupts show receive port first, then first collision, then partition.
// R7: Partition and reconnection reports share priority, served by round-robin polling.
// R8: Reading the live interrupt register clears exactly the interrupt it returned.
// R9: Live interrupt value holds port address in bits 7:4, cause in 3:0.
// R10: Each cause drives its own bit low: receive 1011, partition 0111.
// R11: Live interrupt read with nothing pending returns all ones.
// R12: A three-bit read/write page field selects the visible upper register page.
// R13: Flag-found bit reads 1 while any unmasked flag latch is set.
// R14: Low-count bit is set while any counter is below 00FF hex.
// R15: High-count bit is set while any counter is above C000 hex.
// R16: Full-counter bit is set while any counter equals FFFF hex.
// R17: Lower count mask holds eight per-event count enables, D0 to D7.
// R18: Clear-on-read 1 makes a counter read reset it; 0 leaves it.
// R19: Freeze-full bit stops counters advancing once they reach FFFF.
// R20: Upper count mask has separate transmit and receive collision count enables.
// R21: Software sets both collision enables to count every collision.
// R22: Software sets only the late-collision enable to count late collisions alone.
// R23: Writing 1 to a partition bit reconnects the port; writing 0 does nothing.
// R24: Receive-source bit reads 0 if the port was receive source this packet.
// R25: First-collision cause code is 1101.
package repeater_regs_pkg;
  localparam int PORTS = 13;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_LIVE_IRQ = 8'h0f;
  localparam logic [7:0] IDX_PAGE = 8'h10;
  localparam logic [7:0] IDX_LOWER_MASK = 8'h12;
  localparam logic [7:0] IDX_UPPER_MASK = 8'h13;
  localparam logic [7:0] IDX_OPTIONS = 8'h1e;
  localparam logic [7:0] IDX_PORT_BASE = 8'h20;
  localparam logic [2:0] PAGE_ZERO = 3'h0;
  // Reset values.
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [7:0] LOWER_MASK_RESET = 8'h00;
  localparam logic [7:0] UPPER_MASK_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_RESET = 8'h01;
  // Writable bits of the upper mask; reserved bits stay zero.
  localparam logic [7:0] UPPER_WMASK = 8'h3b;
  // Upper mask fields.
  localparam int UM_CLEAR_ON_READ = 0;
  localparam int UM_FREEZE_FULL = 1;
  localparam int UM_TX_COL = 3;
  localparam int UM_RX_COL = 4;
  localparam int UM_LATE_COL = 5;
  // Per-port register fields.
  localparam int PP_LINK = 0;
  localparam int PP_COL = 1;
  localparam int PP_RX_SRC = 2;
  localparam int PP_PART = 3;
  localparam int PP_CAUSE_LO = 4;
  localparam int PP_SQUELCH = 6;
  localparam int PP_KILL = 7;
  // Option bit 0 is reserved and always reads one.
  localparam int OPT_RESERVED = 0;
  // Live interrupt cause codes.
  localparam logic [3:0] CAUSE_RX = 4'hb;
  localparam logic [3:0] CAUSE_FIRST_COL = 4'hd;
  localparam logic [3:0] CAUSE_PART = 4'h7;
  localparam logic [7:0] NO_IRQ = 8'hff;
  // Counter thresholds.
  localparam logic [15:0] COUNT_LOW = 16'h00ff;
  localparam logic [15:0] COUNT_HIGH = 16'hc000;
  localparam logic [15:0] COUNT_FULL = 16'hffff;
endpackage

/* File: testbench/repeater_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module repeater_regs_props (
  // Clock, reset and bus.
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Port and counter controls.
  input wire logic ext_xcvr_sel,
  input wire logic [12:0] port_kill,
  input wire logic [12:0] squelch_reduced,
  input wire logic [12:0] reconnect,
  input wire logic [7:0] count_enable,
  input wire logic clear_on_read,
  input wire logic freeze_full,
  input wire logic tx_collision_count_en,
  input wire logic rx_collision_count_en,
  input wire logic late_collision_count_en,
  input wire logic [2:0] page_sel
);
  // Transfers taken on an edge; their effects land two edges later.
  wire go = hsel & htrans[1] & hready;
  wire wr = go & hwrite;
  wire rd = go & ~hwrite;
  wire [4:0] upper = {late_collision_count_en, rx_collision_count_en,
    tx_collision_count_en, freeze_full, clear_on_read};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // The data phase is one wait cycle followed by ready.
  sequence s_data_phase;
    !hreadyout ##1 hreadyout;
  endsequence
  // Values seen right after reset may differ from those before it, so that edge is skipped.
  AST_ONE_WAIT: assert property (go |=> s_data_phase)
    else $error("transfer did not end after one wait cycle");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response was not okay");
  AST_SQUELCH_EXT: assert property (ext_xcvr_sel |-> squelch_reduced == 13'h0000)
    else $error("reduced squelch active with external transceivers");
  AST_KILL_WRITE: assert property ($changed(port_kill) && !$past(rst) |-> $past(wr, 2))
    else $error("port disable changed without a write");
  AST_RECON_PULSE: assert property (|reconnect |-> ($past(wr, 2) || $past(wr, 3)) ##1 reconnect == 13'h0000)
    else $error("reconnect pulse without a write or longer than one cycle");
  AST_PAGE_WRITE: assert property ($changed(page_sel) && !$past(rst) |-> $past(wr, 2))
    else $error("page changed without a write");
  AST_LOWER_WRITE: assert property ($changed(count_enable) && !$past(rst) |-> $past(wr, 2))
    else $error("lower count mask changed without a write");
  AST_UPPER_WRITE: assert property ($changed(upper) && !$past(rst) |-> $past(wr, 2))
    else $error("upper count mask changed without a write");
  AST_RDATA_READ: assert property ($changed(hrdata) && !$past(rst) |-> $past(rd, 2))
    else $error("read data changed without a read");
  AST_RDATA_BYTE: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data wider than one byte");
endmodule
bind repeater_port_status_and_event_regs repeater_regs_props i_props (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, rst, hsel, hwrite, hreadyout, hresp, ext_xcvr_sel, mode_load, packet_start;
  logic rx_source_event, first_col_event, flag_found, clear_on_read, freeze_full, seen_rc;
  logic tx_collision_count_en, rx_collision_count_en, late_collision_count_en;
  logic [1:0] htrans;
  logic [2:0] hsize, page_sel;
  logic [3:0] rx_source_port, first_col_port;
  logic [7:0] option_pins, count_enable, q;
  logic [12:0] link_bad, collision_active, rx_active, isolated, isolation_change;
  logic [12:0] port_kill, squelch_reduced, reconnect;
  logic [12:0][1:0] isolation_cause;
  logic [12:0][15:0] counter_value;
  logic [31:0] haddr, hwdata, hrdata;
  wire hready = hreadyout;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  repeater_port_status_and_event_regs i_repeater_port_status_and_event_regs (.*);
  // Clock at 50 ns period.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // The run needs about 130 cycles; the ceiling only catches a hung handshake.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (reconnect[4] === 1'b1) seen_rc <= 1'b1;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ready is looked at just before each edge, so the value equals what that edge samples.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic r;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    hsize <= 3'h2;
    do begin
      @(negedge clock);
      r = hreadyout;
      @(posedge clock);
    end while (r !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do begin
      @(negedge clock);
      r = hreadyout;
      q = hrdata[7:0];
      @(posedge clock);
    end while (r !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check({24'h0, q}, {24'h0, exp});
  endtask
  task automatic t_regs;
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h1e, 8'h01);
    rd(8'h01, 8'h00);
    bus(1'b1, 8'h12, 8'ha5);
    rd(8'h12, 8'ha5);
    check(count_enable, 8'ha5);
    bus(1'b1, 8'h13, 8'hff);
    rd(8'h13, 8'h3b);
    check({late_collision_count_en, rx_collision_count_en, tx_collision_count_en, freeze_full, clear_on_read}, 5'h1f);
    bus(1'b1, 8'h10, 8'h05);
    check(page_sel, 3'h5);
    rd(8'h10, 8'h05);
    rd(8'h12, 8'h00);
    bus(1'b1, 8'h12, 8'h00);
    bus(1'b1, 8'h10, 8'h00);
    rd(8'h12, 8'ha5);
    bus(1'b1, 8'h13, 8'h18);
    check({late_collision_count_en, rx_collision_count_en, tx_collision_count_en}, 3'h3);
    bus(1'b1, 8'h13, 8'h20);
    check({late_collision_count_en, rx_collision_count_en, tx_collision_count_en}, 3'h4);
    mode_load <= 1'b1;
    option_pins <= 8'h5a;
    @(posedge clock);
    mode_load <= 1'b0;
    bus(1'b1, 8'h1e, 8'h00);
    rd(8'h1e, 8'h5b);
    $display("t_regs done");
  endtask
  // One port at a time carries the boundary value, the rest sit in the neutral middle.
  task automatic t_sum;
    logic [15:0] v [5];
    logic [12:0][15:0] cv;
    v = '{16'h00fe, 16'h00ff, 16'hc000, 16'hc001, 16'hffff};
    for (int i = 0; i < 5; i++) begin
      cv = {13{16'h1000}};
      cv[2 * i] = v[i];
      counter_value <= cv;
      flag_found <= i[0];
      @(posedge clock);
      rd(8'h10, {v[i] == 16'hffff, v[i] > 16'hc000, v[i] < 16'h00ff, i[0], 4'h0});
    end
    $display("t_sum done");
  endtask
  task automatic t_port;
    link_bad <= 13'h0010;
    isolated <= 13'h0010;
    rx_active <= 13'h0010;
    collision_active <= 13'h0010;
    @(posedge clock);
    rx_active <= 13'h0000;
    collision_active <= 13'h0000;
    bus(1'b1, 8'h24, 8'hc8);
    repeat (2) @(posedge clock);
    check(seen_rc, 1'b1);
    check(port_kill, 13'h0010);
    check(squelch_reduced, 13'h0010);
    ext_xcvr_sel <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      isolation_cause[4] <= c[1:0];
      @(posedge clock);
      rd(8'h24, {2'b11, c[1:0], 4'h1});
    end
    check(squelch_reduced, 13'h0000);
    bus(1'b1, 8'h24, 8'h00);
    check(port_kill, 13'h0000);
    $display("t_port done");
  endtask
  task automatic t_irq;
    logic [7:0] e [5];
    e = '{8'h3b, 8'h5d, 8'h27, 8'h87, 8'hff};
    rx_source_event <= 1'b1;
    rx_source_port <= 4'h3;
    first_col_event <= 1'b1;
    first_col_port <= 4'h5;
    isolation_change <= 13'h0082;
    @(posedge clock);
    rx_source_event <= 1'b0;
    first_col_event <= 1'b0;
    isolation_change <= 13'h0000;
    for (int i = 0; i < 5; i++) rd(8'h0f, e[i]);
    rx_source_event <= 1'b1;
    isolation_change <= 13'h1000;
    @(posedge clock);
    rx_source_event <= 1'b0;
    isolation_change <= 13'h0000;
    packet_start <= 1'b1;
    @(posedge clock);
    packet_start <= 1'b0;
    rd(8'h0f, 8'hff);
    $display("t_irq done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Every input is given a value at time zero; reset spans three edges.
  initial begin
    {rst, seen_rc, ext_xcvr_sel, mode_load, packet_start, flag_found} = 6'h20;
    {hsel, hwrite, rx_source_event, first_col_event, htrans, hsize} = 9'h002;
    {rx_source_port, first_col_port, option_pins, haddr, hwdata} = 80'h0;
    {link_bad, collision_active, rx_active, isolated, isolation_change} = 65'h0;
    isolation_cause = 26'h0;
    counter_value = {13{16'h1000}};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_sum();
    t_port();
    t_irq();
    test_done();
  end
endmodule
`default_nettype wire
